/* File: hdl/dfs_sequencer.sv */
// Contract
// - Primary array has eight sectors, secondary four, each selectable.
// - Protected sectors are never programmed or erased.
// - B0h suspends a running sector erase; 30h resumes it.
// - Ready/busy is 0 while programming or erasing, 1 otherwise.
// - Every sector of both arrays has its own select input.
// - Primary select high routes to primary array; secondary to secondary.
// - Bus writes never store data; each byte goes to the decoder.
// - Execute only after full byte count with gaps under the time-out.
// - Invalid byte, address or time-out aborts decoding back to read mode; an invalid byte in bypass stays in bypass.
// - Instructions begin AAh at X555h then 55h at XAAAh.
// - Only address bits 11 to 0 are decoded.
// - Unlock pair, 90h at X555h, then read at X002h gives protection.
// - Unlock pair, A0h at X555h, then data at target starts program.
// - Sector erase: six writes ending 30h at sector; more 30h append.
// - Bulk erase: same five writes then 10h at X555h erases the array.
// - Unlock pair with 20h enters bypass; then A0h and data programs.
// - Bypass left by 90h then 00h at even addresses.
// - Address latched on strobe fall, data on strobe rise.
// - Both arrays share the instruction set except identifier read.
// - Status bit 7 reads complement of programmed bit until done.
// - Status bit 6 toggles on each read while busy and selected.
// - Status bit 5 set on failure, held until reset instruction.
`timescale 1ns/1ns
`default_nettype none
module dfs_sequencer #(
   parameter int TIMEOUT = dfs_pkg::TIMEOUT_CYC,   // Inter-byte limit
   parameter int PROG_T  = dfs_pkg::PROG_CYC,      // Program duration
   parameter int ERASE_T = dfs_pkg::ERASE_CYC      // Erase duration, any sector count
) (
   input  wire logic        clock,                 // 50 MHz clock
   input  wire logic        rst_b,                 // Async reset, low
   input  wire logic [dfs_pkg::PRI_SECTORS-1:0] primary_sector_select,
   input  wire logic [dfs_pkg::SEC_SECTORS-1:0] secondary_sector_select,
   input  wire logic        write_strobe_pin_n,    // Write strobe, low
   input  wire logic        read_strobe_n,         // Read strobe, low
   input  wire logic [15:0] bus_addr,              // Bus address
   input  wire logic [7:0]  bus_data,              // Bus write data
   input  wire logic [7:0]  array_rd_data,         // Array byte at addr
   input  wire logic [dfs_pkg::PRI_SECTORS-1:0] pri_protect, // Protected
   input  wire logic [dfs_pkg::SEC_SECTORS-1:0] sec_protect, // Protected
   input  wire logic        op_fail,               // Array reports fault
   output logic             ready_busy_pin,        // 1 ready, 0 busy
   output logic      [7:0]  status_data,           // Read override data
   output logic             status_valid,          // Override active
   output logic             prog_start,            // Program pulse
   output logic      [15:0] program_address,       // Program target
   output logic      [7:0]  program_data,          // Program byte
   output logic             erase_start,           // Erase pulse
   output logic      [11:0] erase_sel,             // Sector mask
   output logic             erase_suspended,       // Suspend level
   output logic             bypass_mode            // Bypass level
);
   import dfs_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic [15:0]   w_addr;
   logic [7:0]    w_data;
   logic          w_done;
   dfs_state_type state_reg, state_next;
   logic [CNT_W-1:0] gap_reg, run_reg;
   logic [11:0]   sel_reg, esel_reg;
   logic          is_erase_reg, err_reg, tog_reg, rd_n_reg;
   logic [7:0]    pd_reg;
   logic [15:0]   pa_reg;
   logic          pstart_reg, estart_reg;

   dfs_strobe_capture u_cap (
      .clock    (clock),
      .rst_b    (rst_b),
      .wr_n     (write_strobe_pin_n),
      .bus_addr (bus_addr),
      .bus_data (bus_data),
      .addr_reg (w_addr),
      .data_reg (w_data),
      .done_reg (w_done)
   );

   function automatic logic cyc_is(input logic [11:0] a,
                                   input logic [7:0] d,
                                   input logic [11:0] ea,
                                   input logic [7:0] ed);
      cyc_is = (a == ea) && (d == ed);
   endfunction : cyc_is

   ////////////////////////////////////////////////////////////////////
   wire [11:0] cur_sel  = {secondary_sector_select, primary_sector_select};
   wire        pri_hit  = |primary_sector_select;
   wire        sec_hit  = |secondary_sector_select;
   wire        any_hit  = pri_hit | sec_hit;
   wire [11:0] a12      = w_addr[11:0];
   wire [11:0] prot_all = {sec_protect, pri_protect};
   wire        cur_prot = |(cur_sel & prot_all);
   wire [11:0] arr_mask = pri_hit ? 12'h0FF : 12'hF00;
   wire        wr_ev    = w_done & any_hit;
   wire        timed_out = (gap_reg >= CNT_W'(TIMEOUT));
   wire        even_a   = ~w_addr[0];
   wire        running  = (state_reg == DFS_BUSY);
   wire        rd_fall  = rd_n_reg & ~read_strobe_n;
   wire        is_unl1  = cyc_is(a12, w_data, UNLOCK1_ADDR, UNLOCK1_DATA);
   wire        is_unl2  = cyc_is(a12, w_data, UNLOCK2_ADDR, UNLOCK2_DATA);
   wire        is_reset = (w_data == CMD_RESET) && even_a;
   wire        run_done = (run_reg == {CNT_W{1'b0}});
   // Decoding mid-sequence states, where the gap timer applies
   wire        in_seq   = (state_reg == DFS_U1) || (state_reg == DFS_U2) ||
                          (state_reg == DFS_PGDATA) ||
                          (state_reg == DFS_E3) || (state_reg == DFS_E4) ||
                          (state_reg == DFS_E5) || (state_reg == DFS_BYP_PG) ||
                          (state_reg == DFS_BYP_EX);

   ////////////////////////////////////////////////////////////////////
   // Next-state decode; outside bypass, busy, suspend and error hold, anything not matching falls back to read mode
   logic       do_prog, do_erase, do_bulk;
   always_comb begin
      state_next = state_reg;
      do_prog    = 1'b0;
      do_erase   = 1'b0;
      do_bulk    = 1'b0;
      if (in_seq && timed_out && any_hit)
         state_next = DFS_READ;
      else if (wr_ev) begin
         case (state_reg)
            DFS_READ, DFS_PROT:
               if (is_unl1) state_next = DFS_U1;
               else state_next = DFS_READ;
            DFS_U1:
               state_next = is_unl2 ? DFS_U2 : DFS_READ;
            DFS_U2:
               if (a12 != UNLOCK1_ADDR) state_next = DFS_READ;
               else if (w_data == CMD_PROT_RD)
                  state_next = DFS_PROT;
               else if (w_data == CMD_PROGRAM)
                  state_next = DFS_PGDATA;
               else if (w_data == CMD_ERASE)
                  state_next = DFS_E3;
               else if (w_data == CMD_BYPASS)
                  state_next = DFS_BYPASS;
               else state_next = DFS_READ;
            DFS_PGDATA: begin
               do_prog    = 1'b1;
               state_next = DFS_BUSY;
            end
            DFS_E3: state_next = is_unl1 ? DFS_E4 : DFS_READ;
            DFS_E4: state_next = is_unl2 ? DFS_E5 : DFS_READ;
            DFS_E5:
               if (w_data == CMD_SECT_ERA) begin
                  do_erase   = 1'b1;
                  state_next = DFS_BUSY;
               end else if (cyc_is(a12, w_data, UNLOCK1_ADDR,
                                   CMD_BULK_ERA)) begin
                  do_bulk    = 1'b1;
                  state_next = DFS_BUSY;
               end else state_next = DFS_READ;
            DFS_BYPASS:
               if (w_data == CMD_PROGRAM && even_a)
                  state_next = DFS_BYP_PG;
               else if (w_data == CMD_PROT_RD && even_a)
                  state_next = DFS_BYP_EX;
            DFS_BYP_PG: begin
               do_prog    = 1'b1;
               state_next = DFS_BUSY;
            end
            DFS_BYP_EX:
               if (w_data == CMD_BYP_EXIT2 && even_a)
                  state_next = DFS_READ;
               else state_next = DFS_BYPASS;
            DFS_BUSY:
               if (w_data == CMD_SUSPEND && even_a && is_erase_reg)
                  state_next = DFS_SUSP;
               else if (w_data == CMD_SECT_ERA && is_erase_reg)
                  do_erase = 1'b1;
            DFS_SUSP:
               if (w_data == CMD_RESUME && even_a)
                  state_next = DFS_BUSY;
            DFS_ERRHLD:
               if (is_reset) state_next = DFS_READ;
            default: state_next = DFS_READ;
         endcase
      end else if (running && run_done)
         state_next = (op_fail || err_reg) ? DFS_ERRHLD
                    : (bypass_mode ? DFS_BYPASS : DFS_READ);
   end

   ////////////////////////////////////////////////////////////////////
   // Protected targets are dropped here: the algorithm still reports busy
   wire [11:0] add_sel  = cur_sel & ~prot_all;
   wire [11:0] bulk_sel = arr_mask & ~prot_all;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= DFS_READ;
         gap_reg      <= {CNT_W{1'b0}};
         run_reg      <= {CNT_W{1'b0}};
         esel_reg     <= 12'h000;
         sel_reg      <= 12'h000;
         is_erase_reg <= 1'b0;
         err_reg      <= 1'b0;
         tog_reg      <= 1'b0;
         rd_n_reg     <= 1'b1;
         pd_reg       <= 8'h00;
         pa_reg       <= 16'h0000;
         pstart_reg   <= 1'b0;
         estart_reg   <= 1'b0;
         bypass_mode  <= 1'b0;
      end else begin
         state_reg  <= state_next;
         rd_n_reg   <= read_strobe_n;
         pstart_reg <= do_prog & ~cur_prot;
         estart_reg <= do_erase | do_bulk;
         if (wr_ev) gap_reg <= {CNT_W{1'b0}};
         else if (!timed_out) gap_reg <= gap_reg + 1'b1;
         if (wr_ev) sel_reg <= cur_sel;
         if (state_next == DFS_BYPASS) bypass_mode <= 1'b1;
         else if (state_next == DFS_READ) bypass_mode <= 1'b0;
         if (do_prog) begin
            pa_reg       <= w_addr;
            pd_reg       <= w_data;
            is_erase_reg <= 1'b0;
            run_reg      <= cur_prot ? CNT_W'(1) : CNT_W'(PROG_T);
         end else if (do_bulk) begin
            is_erase_reg <= 1'b1;
            esel_reg     <= bulk_sel;
            run_reg      <= CNT_W'(ERASE_T);
         end else if (do_erase) begin
            is_erase_reg <= 1'b1;
            esel_reg     <= running ? (esel_reg | add_sel) : add_sel;
            run_reg      <= CNT_W'(ERASE_T);
         end else if (running && !run_done)
            run_reg <= run_reg - 1'b1;
         if (running && run_done && op_fail) err_reg <= 1'b1;
         else if (state_reg == DFS_ERRHLD && wr_ev && is_reset)
            err_reg <= 1'b0;
         if (running && rd_fall && any_hit)
            tog_reg <= ~tog_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status byte replaces array data during busy, protection read, error
   // Read cycle address, not the last latched write address
   wire        prot_q   = (state_reg == DFS_PROT) &&
                          (bus_addr[11:0] == PROT_RD_ADDR);
   logic [7:0] stat_v;
   always_comb begin
      stat_v = 8'h00;
      stat_v[POLL_BIT]   = is_erase_reg ? 1'b0 : ~pd_reg[POLL_BIT];
      stat_v[TOGGLE_BIT] = tog_reg;
      stat_v[ERROR_BIT]  = err_reg;
   end
   wire [7:0] out_v  = prot_q ? {7'h00, cur_prot} : stat_v;
   wire       ov_on  = prot_q || running || (state_reg == DFS_ERRHLD);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ready_busy_pin  <= 1'b1;
         status_data     <= 8'h00;
         status_valid    <= 1'b0;
         prog_start      <= 1'b0;
         program_address <= 16'h0000;
         program_data    <= 8'h00;
         erase_start     <= 1'b0;
         erase_sel       <= 12'h000;
         erase_suspended <= 1'b0;
      end else begin
         ready_busy_pin  <= ~running;
         status_data     <= ov_on ? out_v : array_rd_data;
         status_valid    <= ov_on & any_hit;
         prog_start      <= pstart_reg;
         program_address <= pa_reg;
         program_data    <= pd_reg;
         erase_start     <= estart_reg;
         erase_sel       <= esel_reg;
         erase_suspended <= (state_reg == DFS_SUSP);
      end
   end
endmodule : dfs_sequencer
`default_nettype wire

/* File: include/dfs_pkg.sv */
package dfs_pkg;
   localparam int          PRI_SECTORS   = 8;
   localparam int          SEC_SECTORS   = 4;
   localparam logic [11:0] UNLOCK1_ADDR  = 12'h555;
   localparam logic [11:0] UNLOCK2_ADDR  = 12'hAAA;
   localparam logic [11:0] PROT_RD_ADDR  = 12'h002;
   localparam logic [7:0]  UNLOCK1_DATA  = 8'hAA;
   localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
   localparam logic [7:0]  CMD_PROT_RD   = 8'h90;
   localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
   localparam logic [7:0]  CMD_ERASE     = 8'h80;
   localparam logic [7:0]  CMD_SECT_ERA  = 8'h30;
   localparam logic [7:0]  CMD_BULK_ERA  = 8'h10;
   localparam logic [7:0]  CMD_BYPASS    = 8'h20;
   localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
   localparam logic [7:0]  CMD_RESUME    = 8'h30;
   localparam logic [7:0]  CMD_RESET     = 8'hF0;
   localparam logic [7:0]  CMD_BYP_EXIT2 = 8'h00;
   localparam int          POLL_BIT      = 7;
   localparam int          TOGGLE_BIT    = 6;
   localparam int          ERROR_BIT     = 5;
   localparam int          TIMEOUT_CYC   = 1000;
   localparam int          PROG_CYC      = 16;
   localparam int          ERASE_CYC     = 64;
   localparam int          CNT_W         = 16;

   typedef enum logic [3:0] {
      DFS_READ   = 4'b0000,
      DFS_U1     = 4'b0001,
      DFS_U2     = 4'b0011,
      DFS_PGDATA = 4'b0010,
      DFS_E3     = 4'b0110,
      DFS_E4     = 4'b0111,
      DFS_E5     = 4'b0101,
      DFS_PROT   = 4'b0100,
      DFS_BYPASS = 4'b1100,
      DFS_BYP_PG = 4'b1101,
      DFS_BYP_EX = 4'b1111,
      DFS_BUSY   = 4'b1110,
      DFS_SUSP   = 4'b1010,
      DFS_ERRHLD = 4'b1011
   } dfs_state_type;
endpackage : dfs_pkg

/* File: hdl/dfs_strobe_capture.sv */
`timescale 1ns/1ns
`default_nettype none
// Latches address on the falling write edge and data on the rising edge
module dfs_strobe_capture (
   input  wire logic        clock,      // System clock
   input  wire logic        rst_b,      // Async reset, active low
   input  wire logic        wr_n,       // Write strobe, active low
   input  wire logic [15:0] bus_addr,   // Bus address
   input  wire logic [7:0]  bus_data,   // Bus data
   output logic      [15:0] addr_reg,   // Address latched at fall
   output logic      [7:0]  data_reg,   // Data latched at rise
   output logic             done_reg    // Write complete pulse
);
   logic wr_n_reg;
   wire  fall_edge = wr_n_reg & ~wr_n;
   wire  rise_edge = ~wr_n_reg & wr_n;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_n_reg <= 1'b1;
         addr_reg <= 16'h0000;
         data_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         wr_n_reg <= wr_n;
         done_reg <= rise_edge;
         if (fall_edge) addr_reg <= bus_addr;
         if (rise_edge) data_reg <= bus_data;
      end
   end
endmodule : dfs_strobe_capture
`default_nettype wire

/* File: dv/dfs_seq_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module dfs_seq_properties (
   input wire logic        clock,              // System clock
   input wire logic        rst_b,              // Async reset, low
   input wire logic        write_strobe_pin_n, // Write strobe, low
   input wire logic [7:0]  pri_protect,        // Primary protection
   input wire logic [3:0]  sec_protect,        // Secondary protection
   input wire logic        ready_busy_pin,     // 1 ready, 0 busy
   input wire logic        prog_start,         // Program pulse
   input wire logic        erase_start,        // Erase pulse
   input wire logic [11:0] erase_sel,          // Erase mask
   input wire logic        erase_suspended,    // Suspend level
   input wire logic        bypass_mode         // Bypass level
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////
   logic [7:0] since_rise;
   logic [9:0] busy_cnt;
   // Saturating so an idle bus never wraps into a false cause
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         since_rise <= 8'hFF;
         busy_cnt   <= 10'h000;
      end else begin
         if ($rose(write_strobe_pin_n)) since_rise <= 8'h00;
         else if (since_rise != 8'hFF) since_rise <= since_rise + 8'h01;
         if (ready_busy_pin || erase_suspended) busy_cnt <= 10'h000;
         else if (busy_cnt != 10'h3FF) busy_cnt <= busy_cnt + 10'h001;
      end
   end
   ////////////////////////////////////////////////////////////
   property p_prog_pulse;
      prog_start |=> !prog_start;
   endproperty
   a_prog_pulse: assert property (p_prog_pulse)
      else $error("long prog");
   property p_erase_pulse;
      erase_start |=> !erase_start;
   endproperty
   a_erase_pulse: assert property (p_erase_pulse)
      else $error("long er");
   property p_prog_busy;
      prog_start |-> ##[0:2] !ready_busy_pin [*3];
   endproperty
   a_prog_busy: assert property (p_prog_busy)
      else $error("prog not busy");
   property p_erase_busy;
      erase_start |-> ##[0:2] !ready_busy_pin;
   endproperty
   a_erase_busy: assert property (p_erase_busy)
      else $error("erase idle");
   property p_prog_cause;
      prog_start |-> since_rise <= 8'h08;
   endproperty
   a_prog_cause: assert property (p_prog_cause)
      else $error("stray prog");
   property p_erase_cause;
      erase_start |-> since_rise <= 8'h08;
   endproperty
   a_erase_cause: assert property (p_erase_cause)
      else $error("stray er");
   property p_mask_prot;
      erase_start |-> (erase_sel & {sec_protect, pri_protect}) == 12'h000;
   endproperty
   a_mask_prot: assert property (p_mask_prot)
      else $error("protected erase");
   property p_byp_cause;
      $changed(bypass_mode) |-> since_rise <= 8'h08;
   endproperty
   a_byp_cause: assert property (p_byp_cause)
      else $error("stray bypass");
   property p_susp_cause;
      $changed(erase_suspended) |-> since_rise <= 8'h08;
   endproperty
   a_susp_cause: assert property (p_susp_cause)
      else $error("stray susp");
   property p_busy_bound;
      busy_cnt < 10'h258;
   endproperty
   a_busy_bound: assert property (p_busy_bound)
      else $error("busy stuck");
endmodule : dfs_seq_properties
bind dfs_sequencer dfs_seq_properties u_props (.clock, .rst_b,
   .write_strobe_pin_n, .pri_protect, .sec_protect, .ready_busy_pin,
   .prog_start, .erase_start, .erase_sel, .erase_suspended, .bypass_mode);
`default_nettype wire

/* File: dv/dfs_array_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dfs_array_model (
   input  wire logic [15:0] bus_addr,      // Bus address
   input  wire logic        fail_en,       // Inject array fault
   output logic      [7:0]  array_rd_data, // Byte at address
   output logic             op_fail        // Fault report
);
   // Bytes follow the address so a stale value never passes
   assign array_rd_data = bus_addr[7:0] ^ 8'hC3;
   assign op_fail       = fail_en;
endmodule : dfs_array_model
`default_nettype wire

/* File: dv/dfs_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dfs_sequencer_tb;
   logic        clock = 1'b0, rst_b = 1'b0, fail_en = 1'b0;
   logic [7:0]  primary_sector_select = 8'h00, pri_protect = 8'h08;
   logic [3:0]  secondary_sector_select = 4'h0, sec_protect = 4'h0;
   logic        write_strobe_pin_n = 1'b1, read_strobe_n = 1'b1;
   logic [15:0] bus_addr = 16'h0000, program_address, pa_seen;
   logic [7:0]  bus_data = 8'h00, array_rd_data, status_data;
   logic [7:0]  program_data, pd_seen;
   logic        op_fail, ready_busy_pin, status_valid, prog_start;
   logic        erase_start, erase_suspended, bypass_mode;
   logic [11:0] erase_sel, es_seen = 12'h000;
   logic [8:0]  v1, v2;
   int          mismatches = 0, cmp_count = 0, n_prog = 0;
   always #10 clock = ~clock;
   dfs_sequencer #(.TIMEOUT(50), .PROG_T(20), .ERASE_T(40)) dut (
      .clock, .rst_b, .primary_sector_select, .secondary_sector_select,
      .write_strobe_pin_n, .read_strobe_n, .bus_addr, .bus_data,
      .array_rd_data, .pri_protect, .sec_protect, .op_fail,
      .ready_busy_pin, .status_data, .status_valid, .prog_start,
      .program_address, .program_data, .erase_start, .erase_sel,
      .erase_suspended, .bypass_mode);
   dfs_array_model u_array (.bus_addr, .fail_en, .array_rd_data, .op_fail);
   always @(posedge clock) begin
      if (prog_start === 1'b1) begin
         n_prog  <= n_prog + 1;
         pa_seen <= program_address;
         pd_seen <= program_data;
      end
      if (erase_start === 1'b1) es_seen <= es_seen | erase_sel;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Selects stay up past the write so a gap is seen as addressed
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input logic [11:0] s);
      @(posedge clock);
      {secondary_sector_select, primary_sector_select} <= s;
      bus_addr           <= a;
      bus_data           <= d;
      write_strobe_pin_n <= 1'b0;
      repeat (2) @(posedge clock);
      write_strobe_pin_n <= 1'b1;
      repeat (5) @(posedge clock);
      #1;
   endtask : wr
   task automatic ul(input logic [11:0] s);
      wr(16'hF555, 8'hAA, s);
      wr(16'h3AAA, 8'h55, s);
   endtask : ul
   task automatic rd(input logic [15:0] a, input logic [11:0] s,
                     output logic [8:0] v);
      @(posedge clock);
      {secondary_sector_select, primary_sector_select} <= s;
      bus_addr      <= a;
      read_strobe_n <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      v = {status_valid, status_data};
      @(posedge clock);
      read_strobe_n <= 1'b1;
      @(posedge clock);
   endtask : rd
   task automatic waitr;
      for (int i = 0; i < 800 && ready_busy_pin !== 1'b1; i++)
         @(posedge clock);
      #1;
      chk(16'(ready_busy_pin), 16'h0001);
   endtask : waitr
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   initial begin
      #400000;
      mismatches++;
      conclude();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      rd(16'h0050, 12'h004, v1);
      chk(16'({ready_busy_pin, v1[8]}), 16'h0002);
      ul(12'h004);
      wr(16'h7555, 8'hA0, 12'h004);
      wr(16'h2123, 8'h5A, 12'h004);
      rd(16'h2123, 12'h004, v1);
      rd(16'h2123, 12'h004, v2);
      chk(16'({v1[8], v1[7]}), 16'h0003);
      chk(16'(v1[6] ^ v2[6]), 16'h0001);
      waitr();
      chk(pa_seen, 16'h2123);
      chk(16'({n_prog[7:0], pd_seen}), 16'h015A);
      ul(12'h008);
      wr(16'h0555, 8'hA0, 12'h008);
      wr(16'h3000, 8'h11, 12'h008);
      waitr();
      ul(12'h100);
      wr(16'h0555, 8'hA0, 12'h100);
      wr(16'h0040, 8'h22, 12'h100);
      waitr();
      chk(16'(n_prog), 16'h0002);
      ul(12'h004);
      wr(16'h0555, 8'h12, 12'h004);
      wr(16'h0555, 8'hA0, 12'h004);
      wr(16'h0010, 8'h77, 12'h004);
      ul(12'h004);
      wr(16'h0555, 8'hA0, 12'h004);
      repeat (60) @(posedge clock);
      wr(16'h0020, 8'h66, 12'h004);
      waitr();
      chk(16'(n_prog), 16'h0002);
      ul(12'h002);
      wr(16'h0555, 8'h80, 12'h002);
      ul(12'h002);
      wr(16'h0100, 8'h30, 12'h002);
      wr(16'h0400, 8'h30, 12'h010);
      wr(16'h0600, 8'h30, 12'h008);
      waitr();
      chk(16'(es_seen), 16'h0012);
      ul(12'h100);
      wr(16'h0555, 8'h80, 12'h100);
      ul(12'h100);
      wr(16'h0555, 8'h10, 12'h100);
      waitr();
      // Masks accumulate, so the sector erase bits remain
      chk(16'(es_seen), 16'h0F12);
      ul(12'h001);
      wr(16'h0555, 8'h80, 12'h001);
      ul(12'h001);
      wr(16'h0000, 8'h30, 12'h001);
      wr(16'h0000, 8'hB0, 12'h001);
      chk(16'(erase_suspended), 16'h0001);
      wr(16'h0000, 8'h30, 12'h001);
      chk(16'(erase_suspended), 16'h0000);
      waitr();
      ul(12'h004);
      wr(16'h0555, 8'h20, 12'h004);
      chk(16'(bypass_mode), 16'h0001);
      wr(16'h0000, 8'hA0, 12'h004);
      wr(16'h1010, 8'h33, 12'h004);
      waitr();
      chk(pa_seen, 16'h1010);
      wr(16'h0000, 8'h90, 12'h004);
      wr(16'h0000, 8'h00, 12'h004);
      chk(16'(bypass_mode), 16'h0000);
      ul(12'h008);
      wr(16'h0555, 8'h90, 12'h008);
      rd(16'h0002, 12'h008, v1);
      rd(16'hF002, 12'h004, v2);
      chk(16'(v1), 16'h0101);
      chk(16'(v2), 16'h0100);
      fail_en <= 1'b1;
      ul(12'h004);
      wr(16'h0555, 8'hA0, 12'h004);
      wr(16'h0030, 8'h44, 12'h004);
      waitr();
      fail_en <= 1'b0;
      rd(16'h0030, 12'h004, v1);
      chk(16'({v1[8], v1[5]}), 16'h0003);
      wr(16'h0000, 8'hF0, 12'h004);
      rd(16'h0030, 12'h004, v1);
      chk(16'(v1[8]), 16'h0000);
      conclude();
   end
endmodule : dfs_sequencer_tb
`default_nettype wire
